// >>> dpt_pkg.sv
// Purpose: Shared constants and types for the dual phase PWM interval timer
// Assumes: One 100 MHz system clock; timer clocks arrive as tick pulses
// Notes:   All counts and codes used by more than one file live here
package dpt_pkg;
	localparam int          DPT_CNT_W       = 16;       // Counter and reload width
	localparam int          DPT_FDIV_W      = 2;        // Fast divider field width
	localparam int          DPT_PRE_W       = 3;        // Fast prescale counter width
	localparam int          DPT_DEC_W       = 4;        // Divide-by-ten counter width
	localparam logic [15:0] DPT_RELOAD_RST  = 16'h0000; // Reload reset value
	localparam logic [15:0] DPT_CNT_ZERO    = 16'h0000; // Counter empty value
	localparam logic [15:0] DPT_CNT_ONE     = 16'h0001; // Decrement step
	localparam logic [3:0]  DPT_DEC_LAST    = 4'h9;     // Tenth tick of ten
	localparam logic [3:0]  DPT_DEC_ONE     = 4'h1;     // Decade step
	localparam logic [3:0]  DPT_DEC_RST     = 4'h0;     // Decade reset value
	localparam logic [2:0]  DPT_PRE_ONE     = 3'h1;     // Prescale step
	localparam logic [2:0]  DPT_PRE_RST     = 3'h0;     // Prescale reset value

	// Fast clock divider codes: 16, 8, 4 or 2 MHz from the 16 MHz tick
	typedef enum logic [1:0] {
		DPT_FDIV_1 = 2'h0,
		DPT_FDIV_2 = 2'h1,
		DPT_FDIV_4 = 2'h2,
		DPT_FDIV_8 = 2'h3
	} dpt_fdiv_type;

	// Configuration bits steering the clocking and output shape
	typedef struct packed {
		logic         clock_source_select;   // 0 slow clock, 1 fast clocks
		logic         fast_clock_gate;       // Gate for the fast clocks
		dpt_fdiv_type fast_clock_divider;    // Fast clock divide code
		logic         interval_div10_select; // Interval counter divided by ten
		logic         pwm_burst_select;      // Clock burst during high phase
	} dpt_cfg_type;

	// One reload write: strobe plus data
	typedef struct packed {
		logic                 wr;   // One-cycle write strobe
		logic [DPT_CNT_W-1:0] data; // Value written
	} dpt_wr_type;
endpackage : dpt_pkg

// >>> dpt_tick_gen.sv
// Purpose: Produce the timer tick and the interval counter tick
// Assumes: Tick inputs are one-cycle pulses synchronous to clk
// Notes:   Counters clear while disabled and hold while frozen so ticks stay aligned
`timescale 1ns/1ps
`default_nettype none
module dpt_tick_gen
	import dpt_pkg::*;
(
	input  wire logic              clk,           // System clock
	input  wire logic              rst_n,         // Async reset, active low
	input  wire logic              run,           // Timer enabled; freeze comes on hold
	input  wire logic              hold,          // Freeze: keep counts
	input  wire logic              fast_tick_in,  // 16 MHz tick
	input  wire logic              slow_tick_in,  // 32 kHz tick
	input  wire dpt_pkg::dpt_cfg_type cfg,        // Clock configuration
	output logic                   timer_tick,    // Selected timer clock
	output logic                   interval_tick  // Interval counter clock
);
	import dpt_pkg::*;

	logic [DPT_PRE_W-1:0] pre_reg;   // Fast prescale count
	logic [DPT_DEC_W-1:0] dec_reg;   // Divide-by-ten count
	logic [DPT_PRE_W-1:0] pre_mask;  // Count pattern marking a divided tick
	logic                 fast_on;   // Fast clock path selected and gated

	// Fast path needs both the select and the gate; slow needs no gate
	assign fast_on = cfg.clock_source_select & cfg.fast_clock_gate; // [RULE2]

	// Mask of the prescale bits that must all be set
	always_comb begin
		unique case (cfg.fast_clock_divider)
			DPT_FDIV_1: pre_mask = 3'h0;
			DPT_FDIV_2: pre_mask = 3'h1;
			DPT_FDIV_4: pre_mask = 3'h3;
			DPT_FDIV_8: pre_mask = 3'h7;
		endcase
	end

	// Select stops the clock if the fast path is chosen but not gated
	assign timer_tick = cfg.clock_source_select ?
		(fast_on & fast_tick_in & ((pre_reg & pre_mask) == pre_mask)) :
		slow_tick_in; // [RULE2]

	// Divide-by-ten only feeds the interval counter
	assign interval_tick = cfg.interval_div10_select ?
		(timer_tick & (dec_reg == DPT_DEC_LAST)) : timer_tick; // [RULE3]

	// Prescaler on the fast tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_reg <= DPT_PRE_RST;
		end else if (!run) begin
			pre_reg <= DPT_PRE_RST;
		end else if (fast_on && fast_tick_in && !hold) begin
			pre_reg <= pre_reg + DPT_PRE_ONE;
		end
	end

	// Decade counter on the timer tick
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_reg <= DPT_DEC_RST;
		end else if (!run) begin
			dec_reg <= DPT_DEC_RST;
		end else if (timer_tick && !hold) begin
			dec_reg <= (dec_reg == DPT_DEC_LAST) ? DPT_DEC_RST : dec_reg + DPT_DEC_ONE; // [RULE3]
		end
	end
endmodule : dpt_tick_gen
`default_nettype wire

// >>> dpt_timer.sv
// Purpose: Dual phase PWM generator with a separate interval interrupt timer
// Assumes: Timer clocks arrive as tick pulses synchronous to clk
// Notes:   Reload registers and the freeze flag survive disable; everything else resets
// What this block does
// RULE1: Counters and reloads are 16 bits, reset zero
// RULE2: Clock from 16/8/4/2 MHz or 32 kHz
// RULE3: Divide-by-ten option applies to interval counter only
// RULE4: Run raises interrupt and loads both counters
// RULE5: Phase counter at zero toggles phase, reloads
// RULE6: True output high in high phase; inverse complements
// RULE7: Burst mode outputs timer clock halved when high
// RULE8: Interval holds zero; interrupt at low-phase end
// RULE9: At interrupt reload counters and both shadows
// RULE10: Reload writes reach shadows only at cycle end
// RULE11: Start-up state gives an immediate interrupt
// RULE12: Disabled timer resets all except reload registers and the freeze flag
// RULE13: Interval readback returns live interval counter
// RULE14: Phase readbacks return live phase counter
// RULE15: Freeze stops counting until freeze cleared
// RULE16: Period is high plus low reloads plus two
// RULE17: Interrupt interval is interval reload plus one
// RULE18: Software: interval timing uses zero phase reloads
// RULE19: Software: long timing uses 65535 high reload
// RULE20: Software: slow clock needs divider field zero
// RULE21: Each interrupt is a single-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module dpt_timer
	import dpt_pkg::*;
#(
	parameter int CNT_W = dpt_pkg::DPT_CNT_W  // Counter width
)
(
	input  wire logic                 clk,                 // 100 MHz system clock
	input  wire logic                 rst_n,               // Async reset, active low
	input  wire logic                 timer_run,           // Enable, level
	input  wire dpt_pkg::dpt_cfg_type cfg,                 // Clock and output config
	input  wire logic                 fast_tick_in,        // 16 MHz tick pulse
	input  wire logic                 slow_tick_in,        // 32 kHz tick pulse
	input  wire dpt_pkg::dpt_wr_type  high_phase_wr,       // High phase reload write
	input  wire dpt_pkg::dpt_wr_type  low_phase_wr,        // Low phase reload write
	input  wire dpt_pkg::dpt_wr_type  interval_wr,         // Interval reload write
	input  wire logic                 freeze_set,          // Freeze set pulse
	input  wire logic                 freeze_clear,        // Freeze clear pulse
	output logic                      freeze_timer,        // Freeze state
	output logic [CNT_W-1:0]          interval_read_data,  // Live interval counter
	output logic [CNT_W-1:0]          phase_read_data,     // Live phase counter
	output logic                      pwm_true_out,        // PWM output
	output logic                      pwm_inverted_out,    // Inverted PWM output
	output logic                      timer_interrupt      // Interrupt pulse
);
	import dpt_pkg::*;

	// Reload registers: kept through disable
	logic [CNT_W-1:0] high_phase_reload;  // High phase reload
	logic [CNT_W-1:0] low_phase_reload;   // Low phase reload
	logic [CNT_W-1:0] interval_reload;    // Interval reload
	// Working state: reset while disabled, except the freeze flag
	logic [CNT_W-1:0] phase_counter_reg;  // Phase counter
	logic [CNT_W-1:0] interval_cnt_reg;   // Interval counter
	logic [CNT_W-1:0] high_shadow_reg;    // High phase shadow
	logic [CNT_W-1:0] low_shadow_reg;     // Low phase shadow
	logic             phase_select_reg;   // 1 while counting low phase
	logic             started_reg;        // Start load done
	logic             burst_reg;          // Halved timer clock for bursts
	logic             irq_reg;            // Interrupt pulse
	logic             pwm_reg;            // Registered PWM level
	logic             freeze_reg;         // Freeze flag
	// Decoded events
	logic             timer_tick;         // Selected timer clock tick
	logic             interval_tick;      // Interval counter tick
	logic             step;               // Tick that may move the counters
	logic             start_ev;           // First load after enable
	logic             phase_zero;         // Phase counter empty
	logic             interval_zero;      // Interval counter empty
	logic             wrap_ev;            // End of a full cycle
	logic             pwm_next;           // Next PWM level

	// Tick source: prescaler, gate and divide-by-ten
	dpt_tick_gen u_tick (
		.clk           (clk),
		.rst_n         (rst_n),
		.run           (timer_run),
		.hold          (freeze_reg),
		.fast_tick_in  (fast_tick_in),
		.slow_tick_in  (slow_tick_in),
		.cfg           (cfg),
		.timer_tick    (timer_tick),
		.interval_tick (interval_tick)
	);

	// Event decode; freeze blocks the counter step and the start load
	assign step          = timer_tick & timer_run & started_reg & ~freeze_reg; // [RULE15]
	assign start_ev      = timer_run & ~started_reg & ~freeze_reg;
	assign phase_zero    = (phase_counter_reg == DPT_CNT_ZERO);
	assign interval_zero = (interval_cnt_reg == DPT_CNT_ZERO);
	// Cycle ends only at low-phase zero with interval already empty
	assign wrap_ev = step & phase_zero & phase_select_reg & interval_zero; // [RULE8]

	// Reload registers accept writes at any time, even while disabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_phase_reload <= DPT_RELOAD_RST; // [RULE1]
			low_phase_reload  <= DPT_RELOAD_RST;
			interval_reload   <= DPT_RELOAD_RST;
		end else begin
			if (high_phase_wr.wr) begin
				high_phase_reload <= high_phase_wr.data; // [RULE10]
			end
			if (low_phase_wr.wr) begin
				low_phase_reload <= low_phase_wr.data;
			end
			if (interval_wr.wr) begin
				interval_reload <= interval_wr.data;
			end
		end
	end

	// Freeze flag: a set in the same cycle as a clear wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freeze_reg <= 1'b0;
		end else if (freeze_set) begin
			freeze_reg <= 1'b1; // [RULE15]
		end else if (freeze_clear) begin
			freeze_reg <= 1'b0;
		end
	end

	// Start marker; dropping the enable rearms the start load
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			started_reg <= 1'b0;
		end else if (!timer_run) begin
			started_reg <= 1'b0; // [RULE12]
		end else if (start_ev) begin
			started_reg <= 1'b1;
		end
	end

	// Phase counter and phase select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_counter_reg <= DPT_CNT_ZERO; // [RULE1]
			phase_select_reg  <= 1'b1;
		end else if (!timer_run) begin
			// Zero counter in low phase makes start look like a cycle end
			phase_counter_reg <= DPT_CNT_ZERO; // [RULE12] [RULE11]
			phase_select_reg  <= 1'b1;
		end else if (start_ev || wrap_ev) begin
			phase_counter_reg <= high_phase_reload; // [RULE4] [RULE9]
			phase_select_reg  <= 1'b0;
		end else if (step) begin
			if (!phase_zero) begin
				phase_counter_reg <= phase_counter_reg - DPT_CNT_ONE; // [RULE16]
			end else if (!phase_select_reg) begin
				phase_counter_reg <= low_shadow_reg; // [RULE5]
				phase_select_reg  <= 1'b1;
			end else begin
				// Low phase over but interval still running: another high phase
				phase_counter_reg <= high_shadow_reg; // [RULE5]
				phase_select_reg  <= 1'b0;
			end
		end
	end

	// Interval counter: holds at zero until the cycle end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			interval_cnt_reg <= DPT_CNT_ZERO; // [RULE1]
		end else if (!timer_run) begin
			interval_cnt_reg <= DPT_CNT_ZERO; // [RULE12]
		end else if (start_ev || wrap_ev) begin
			interval_cnt_reg <= interval_reload; // [RULE4] [RULE9] [RULE17]
		end else if (step && interval_tick && !interval_zero) begin
			interval_cnt_reg <= interval_cnt_reg - DPT_CNT_ONE; // [RULE8] [RULE3]
		end
	end

	// Shadows copy the reloads only at start or cycle end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_shadow_reg <= DPT_CNT_ZERO;
			low_shadow_reg  <= DPT_CNT_ZERO;
		end else if (!timer_run) begin
			high_shadow_reg <= DPT_CNT_ZERO; // [RULE12]
			low_shadow_reg  <= DPT_CNT_ZERO;
		end else if (start_ev || wrap_ev) begin
			high_shadow_reg <= high_phase_reload; // [RULE10] [RULE9]
			low_shadow_reg  <= low_phase_reload;
		end
	end

	// Burst clock: timer tick halved, 50% duty
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_reg <= 1'b0;
		end else if (!timer_run) begin
			burst_reg <= 1'b0; // [RULE12]
		end else if (timer_tick && !freeze_reg) begin
			burst_reg <= ~burst_reg; // [RULE7]
		end
	end

	// Next PWM level from the phase about to be counted
	always_comb begin
		pwm_next = 1'b0;
		if (timer_run) begin
			if (start_ev || wrap_ev) begin
				// Burst opens on the level the burst flop takes at this edge,
				// otherwise the first high clock would repeat and skew the duty
				pwm_next = 1'b1; // [RULE6]
				if (cfg.pwm_burst_select) begin
					pwm_next = timer_tick ? ~burst_reg : burst_reg; // [RULE7]
				end
			end else if (step && phase_zero) begin
				pwm_next = phase_select_reg & (cfg.pwm_burst_select ? ~burst_reg : 1'b1);
			end else if (!phase_select_reg && started_reg) begin
				// Burst toggles on each tick; steady high otherwise
				if (cfg.pwm_burst_select) begin
					pwm_next = (timer_tick && !freeze_reg) ? ~burst_reg : burst_reg; // [RULE7]
				end else begin
					pwm_next = 1'b1;
				end
			end
		end
	end

	// PWM level register; outputs come from this flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_reg <= 1'b0;
		end else begin
			pwm_reg <= pwm_next; // [RULE6] [RULE12]
		end
	end

	// Interrupt pulse: one cycle at start and at each cycle end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= start_ev | wrap_ev; // [RULE4] [RULE8] [RULE11] [RULE21]
		end
	end

	// Outputs; readbacks show live counters, never the reloads
	assign pwm_true_out       = pwm_reg;
	assign pwm_inverted_out   = ~pwm_reg;            // [RULE6]
	assign timer_interrupt    = irq_reg;
	assign freeze_timer       = freeze_reg;
	assign interval_read_data = interval_cnt_reg;    // [RULE13]
	assign phase_read_data    = phase_counter_reg;   // [RULE14]

	// Enable from reset state gives an interrupt next cycle
	property p_start_irq;
		@(posedge clk) disable iff (!rst_n)
		(timer_run && !started_reg && !freeze_reg) |=> timer_interrupt;
	endproperty
	a_start_irq: assert property (p_start_irq) // [RULE4] [RULE11]
		else $error("no interrupt on timer start");

	// Complement holds every cycle
	property p_inverse;
		@(posedge clk) disable iff (!rst_n)
		pwm_inverted_out == !pwm_true_out;
	endproperty
	a_inverse: assert property (p_inverse) // [RULE6]
		else $error("inverted output not the complement");

	// Disabled timer clears its working state
	property p_disabled;
		@(posedge clk) disable iff (!rst_n)
		!timer_run |=> (phase_read_data == DPT_CNT_ZERO) && (interval_read_data == DPT_CNT_ZERO)
			&& !pwm_true_out && !timer_interrupt;
	endproperty
	a_disabled: assert property (p_disabled) // [RULE12]
		else $error("disabled timer not in reset state");

	// Frozen timer keeps both counters
	property p_freeze;
		@(posedge clk) disable iff (!rst_n)
		(freeze_reg && timer_run) |=> $stable(phase_counter_reg) && $stable(interval_cnt_reg);
	endproperty
	a_freeze: assert property (p_freeze) // [RULE15]
		else $error("counter moved while frozen");

	// End of high phase switches to the low shadow
	property p_toggle;
		@(posedge clk) disable iff (!rst_n)
		(timer_run && step && phase_zero && !phase_select_reg)
			|=> phase_select_reg && (phase_counter_reg == $past(low_shadow_reg));
	endproperty
	a_toggle: assert property (p_toggle) // [RULE5]
		else $error("phase did not switch to low value");

	// Cycle end reloads and interrupts
	property p_wrap;
		@(posedge clk) disable iff (!rst_n)
		(timer_run && wrap_ev) |=> timer_interrupt && !phase_select_reg
			&& (interval_cnt_reg == $past(interval_reload))
			&& (phase_counter_reg == $past(high_phase_reload))
			&& (low_shadow_reg == $past(low_phase_reload));
	endproperty
	a_wrap: assert property (p_wrap) // [RULE8] [RULE9]
		else $error("cycle end did not reload");

	// Shadows stay put inside a running cycle
	property p_shadow;
		@(posedge clk) disable iff (!rst_n)
		(timer_run && started_reg && !wrap_ev)
			|=> $stable(high_shadow_reg) && $stable(low_shadow_reg);
	endproperty
	a_shadow: assert property (p_shadow) // [RULE10]
		else $error("shadow changed mid cycle");

	// Empty interval counter stays empty until the cycle end
	property p_interval_hold;
		@(posedge clk) disable iff (!rst_n)
		(timer_run && started_reg && interval_zero && !wrap_ev) |=> interval_zero;
	endproperty
	a_interval_hold: assert property (p_interval_hold) // [RULE8]
		else $error("interval counter left zero");

	// Interrupt never lasts two cycles
	property p_irq_pulse;
		@(posedge clk) disable iff (!rst_n)
		timer_interrupt |=> !timer_interrupt;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) // [RULE21]
		else $error("interrupt longer than one cycle");

	// Low phase drives the output low
	property p_low_phase;
		@(posedge clk) disable iff (!rst_n)
		(timer_run && started_reg && phase_select_reg && !step) |=> !pwm_true_out;
	endproperty
	a_low_phase: assert property (p_low_phase) // [RULE6]
		else $error("output high during low phase");

	// Burst level follows the halved tick through the high phase
	property p_burst;
		@(posedge clk) disable iff (!rst_n)
		(cfg.pwm_burst_select && (wrap_ev || (step && !phase_select_reg && !phase_zero)))
			|=> (pwm_true_out == burst_reg);
	endproperty
	a_burst: assert property (p_burst) // [RULE7]
		else $error("burst level off the halved tick");
endmodule : dpt_timer
`default_nettype wire

// >>> dpt_timer_tb.sv
// Purpose: Self-checking bench for the dual phase PWM interval timer
// Assumes: Fast tick held high means a tick on every clock; slow tick every 8 clocks
// Notes:   Periods are counted in clocks from one interrupt pulse to the next
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_tb;
	import dpt_pkg::*;
	logic        clk;                // System clock
	logic        rst_n;              // Async reset, active low
	logic        timer_run;          // Enable level
	dpt_cfg_type cfg;                // Clock and output setup
	logic        fast_tick_in;       // Fast tick, every clock when high
	logic        slow_tick_in;       // Slow tick pulse
	dpt_wr_type  high_phase_wr;      // High phase reload write
	dpt_wr_type  low_phase_wr;       // Low phase reload write
	dpt_wr_type  interval_wr;        // Interval reload write
	logic        freeze_set;         // Freeze set pulse
	logic        freeze_clear;       // Freeze clear pulse
	logic        freeze_timer;       // Freeze state
	logic [15:0] interval_read_data; // Live interval counter
	logic [15:0] phase_read_data;    // Live phase counter
	logic        pwm_true_out;       // PWM output
	logic        pwm_inverted_out;   // Inverted PWM output
	logic        timer_interrupt;    // Interrupt pulse
	logic [2:0]  slow_cnt;           // Slow tick spacing
	int          n_mismatch;         // Mismatches seen
	int          checks_done;        // Comparisons made

	dpt_timer dut (.clk(clk), .rst_n(rst_n), .timer_run(timer_run), .cfg(cfg),
		.fast_tick_in(fast_tick_in), .slow_tick_in(slow_tick_in),
		.high_phase_wr(high_phase_wr), .low_phase_wr(low_phase_wr),
		.interval_wr(interval_wr), .freeze_set(freeze_set), .freeze_clear(freeze_clear),
		.freeze_timer(freeze_timer), .interval_read_data(interval_read_data),
		.phase_read_data(phase_read_data), .pwm_true_out(pwm_true_out),
		.pwm_inverted_out(pwm_inverted_out), .timer_interrupt(timer_interrupt));

	// Free running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Slow tick every 8 clocks, the same spacing as the fast divide by 8
	always @(posedge clk) begin
		slow_cnt     <= slow_cnt + 3'h1;
		slow_tick_in <= (slow_cnt == 3'h3);
	end

	// One comparison; case inequality so an unknown never matches
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
			n_mismatch++;
		end
	endtask : check

	// Bounded wait for the next interrupt pulse
	task automatic wait_irq(input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if (timer_interrupt === 1'b1) return;
		end
		check(16'h0, 16'h1, "interrupt missing");
	endtask : wait_irq

	// Count clocks and high clocks up to the next interrupt; called in an interrupt cycle, except the first call in t_shadow
	task automatic measure(input int exp_p, input int exp_h, input bit judge);
		int p;
		int h;
		p = 0;
		h = (pwm_true_out === 1'b1) ? 1 : 0;
		while (p < 2000) begin
			@(posedge clk);
			#1;
			p++;
			check({15'h0, pwm_inverted_out}, {15'h0, ~pwm_true_out}, "inverse");
			if (timer_interrupt === 1'b1) break;
			h += (pwm_true_out === 1'b1) ? 1 : 0;
		end
		if (judge) begin
			check(p[15:0], exp_p[15:0], "period");
			check(h[15:0], exp_h[15:0], "high time");
		end
	endtask : measure

	// Stop, load reloads while disabled, start; start interrupt comes next cycle
	task automatic setup(input dpt_cfg_type c, input logic [15:0] m, input logic [15:0] n,
		input logic [15:0] on);
		@(posedge clk);
		timer_run     <= 1'b0;
		cfg           <= c;
		high_phase_wr <= '{1'b1, m};
		low_phase_wr  <= '{1'b1, n};
		interval_wr   <= '{1'b1, on};
		@(posedge clk);
		high_phase_wr.wr <= 1'b0;
		low_phase_wr.wr  <= 1'b0;
		interval_wr.wr   <= 1'b0;
		@(posedge clk);
		timer_run <= 1'b1;
		wait_irq(2);
	endtask : setup

	// Quiet state after power-on reset
	task automatic t_reset();
		@(posedge clk);
		#1;
		check(phase_read_data, 16'h0000, "phase reset");
		check(interval_read_data, 16'h0000, "interval reset");
		check({13'h0, pwm_true_out, pwm_inverted_out, timer_interrupt}, 16'h2, "outs");
	endtask : t_reset

	// Start load, readback, single pulse, period and duty
	task automatic t_basic(input dpt_cfg_type c);
		setup(c, 16'h2, 16'h1, 16'h0);
		check(phase_read_data, 16'h2, "phase start");
		check({15'h0, pwm_true_out}, 16'h1, "pwm start");
		measure(5, 3, 1'b1);
		measure(5, 3, 1'b1);
		setup(c, 16'h0, 16'h0, 16'h5);
		check(interval_read_data, 16'h5, "interval start");
		measure(6, 3, 1'b1);
	endtask : t_basic

	// Interval divided by ten while the phase counter keeps full rate
	task automatic t_div10(input dpt_cfg_type c);
		int h;
		h = 0;
		c.interval_div10_select = 1'b1;
		setup(c, 16'h0, 16'h0, 16'h1);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			check({15'h0, timer_interrupt}, 16'h0, "early interrupt");
			h += (pwm_true_out === 1'b1) ? 1 : 0;
		end
		check(h[15:0], 16'h4, "phase rate");
	endtask : t_div10

	// Burst: high phase carries the tick halved, half of its clocks high
	task automatic t_burst(input dpt_cfg_type c);
		c.pwm_burst_select = 1'b1;
		setup(c, 16'h7, 16'h7, 16'h0);
		measure(16, 4, 1'b0);
		measure(16, 4, 1'b1);
	endtask : t_burst

	// The fast divide codes for 2, 4 and 8, the slow clock, and a closed fast gate
	task automatic t_clksel(input dpt_cfg_type c);
		for (int d = 1; d < 4; d++) begin
			c.fast_clock_divider = dpt_fdiv_type'(d);
			setup(c, 16'h1, 16'h0, 16'h0);
			measure(0, 0, 1'b0);
			measure(3 << d, 2 << d, 1'b1);
		end
		c.clock_source_select = 1'b0;
		c.fast_clock_divider  = DPT_FDIV_1;
		setup(c, 16'h1, 16'h0, 16'h0);
		measure(0, 0, 1'b0);
		measure(24, 16, 1'b1);
		c.clock_source_select = 1'b1;
		c.fast_clock_gate     = 1'b0;
		setup(c, 16'h1, 16'h0, 16'h0);
		repeat (30) @(posedge clk);
		#1;
		check(phase_read_data, 16'h1, "gated count");
	endtask : t_clksel

	// New reloads mid-cycle wait for the cycle end
	task automatic t_shadow(input dpt_cfg_type c);
		setup(c, 16'h2, 16'h1, 16'h0);
		@(posedge clk);
		high_phase_wr <= '{1'b1, 16'h0};
		low_phase_wr  <= '{1'b1, 16'h0};
		@(posedge clk);
		high_phase_wr.wr <= 1'b0;
		low_phase_wr.wr  <= 1'b0;
		#1;
		measure(3, 1, 1'b1);
		measure(2, 1, 1'b1);
	endtask : t_shadow

	// Freeze holds state, set wins over clear, clear resumes; then disable
	task automatic t_freeze(input dpt_cfg_type c);
		logic [15:0] ph;
		setup(c, 16'h9, 16'h9, 16'h0);
		@(posedge clk);
		freeze_set <= 1'b1;
		@(posedge clk);
		freeze_clear <= 1'b1;
		@(posedge clk);
		freeze_set   <= 1'b0;
		freeze_clear <= 1'b0;
		#1;
		ph = phase_read_data;
		repeat (20) @(posedge clk);
		#1;
		check({15'h0, freeze_timer}, 16'h1, "freeze flag");
		check(phase_read_data, ph, "frozen count");
		@(posedge clk);
		freeze_clear <= 1'b1;
		@(posedge clk);
		freeze_clear <= 1'b0;
		wait_irq(40);
		@(posedge clk);
		timer_run <= 1'b0;
		@(posedge clk);
		#1;
		check({phase_read_data[13:0], pwm_true_out, pwm_inverted_out}, 16'h1, "off");
		check({interval_read_data[14:0], timer_interrupt}, 16'h0, "off irq");
		@(posedge clk);
		timer_run <= 1'b1;
		wait_irq(2);
		check(phase_read_data, 16'h9, "reload kept");
	endtask : t_freeze

	// Long count: full high reload plus a short low phase spans 17 bits
	task automatic t_long(input dpt_cfg_type c);
		int p;
		p = 0;
		setup(c, 16'hffff, 16'h1, 16'h0);
		check(phase_read_data, 16'hffff, "long start");
		while (p < 70000) begin
			@(posedge clk);
			#1;
			p++;
			if (timer_interrupt === 1'b1) break;
		end
		check(p[31:16], 16'h1, "long period upper");
		check(p[15:0], 16'h2, "long period lower");
	endtask : t_long

	// Verdict and end of run
	task automatic tally_and_finish();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	// Hang guard, past the roughly 70,000 clocks the tests need
	initial begin
		#950000;
		n_mismatch++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		dpt_cfg_type c;
		c = '{1'b1, 1'b1, DPT_FDIV_1, 1'b0, 1'b0};
		n_mismatch = 0;
		checks_done = 0;
		rst_n = 1'b0;
		timer_run = 1'b0;
		cfg = c;
		fast_tick_in = 1'b1;
		slow_tick_in = 1'b0;
		slow_cnt = 3'h0;
		high_phase_wr = '0;
		low_phase_wr = '0;
		interval_wr = '0;
		freeze_set = 1'b0;
		freeze_clear = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_basic(c);
		t_div10(c);
		t_burst(c);
		t_clksel(c);
		t_shadow(c);
		t_freeze(c);
		t_long(c);
		tally_and_finish();
	end
endmodule : dpt_timer_tb
`default_nettype wire
